// *** inc/pab_regs.vh ***
// register map, field layout and mode encodings of the port a/b gpio block
`ifndef PAB_GPIO_REGS_VH
`define PAB_GPIO_REGS_VH

// widths
`define PAB_ADDR_W 4
`define PAB_DATA_W 8
`define PAB_EXT_ADDR_W 16

// register offsets
`define PAB_OFF_A_DATA 4'h0
`define PAB_OFF_B_DATA 4'h1
`define PAB_OFF_A_DIR 4'h2
`define PAB_OFF_B_DIR 4'h3
`define PAB_OFF_STATUS 4'h4
`define PAB_OFF_A_PINS 4'h5
`define PAB_OFF_B_PINS 4'h6

// register select codes returned by the decoder
`define PAB_SEL_NONE 3'h0
`define PAB_SEL_A_DATA 3'h1
`define PAB_SEL_B_DATA 3'h2
`define PAB_SEL_A_DIR 3'h3
`define PAB_SEL_B_DIR 3'h4
`define PAB_SEL_STATUS 3'h5
`define PAB_SEL_A_PINS 3'h6
`define PAB_SEL_B_PINS 3'h7

// reset values
`define PAB_RST_DIR 8'h00
`define PAB_RST_DATA 8'h00
`define PAB_RST_ZERO 8'h00

// operating mode encodings on i_mode
`define PAB_MODE_SINGLE 2'b00
`define PAB_MODE_NORM_EXP 2'b01
`define PAB_MODE_EMU_SINGLE 2'b10
`define PAB_MODE_EMU_EXP 2'b11

// status register fields
`define PAB_ST_EXPANDED 0
`define PAB_ST_EMULATION 1
`define PAB_ST_A_OWNED 2
`define PAB_ST_B_OWNED 3
`define PAB_ST_UDS_IN 4
`define PAB_ST_IVD_PHASE 5

// port b pin that carries the upper data select input
`define PAB_UDS_BIT 0

// address byte fields
`define PAB_ADDR_LO_MSB 7
`define PAB_ADDR_LO_LSB 0
`define PAB_ADDR_HI_MSB 15
`define PAB_ADDR_HI_LSB 8

`endif

// *** hw/pab_sync.v ***
// two flip-flop synchroniser for asynchronous pin inputs
`timescale 1ns/100ps
module pab_sync #(
    parameter W = 8
) (
    // clock and reset
    input wire i_core_clk,
    input wire i_rst,
    // asynchronous input and synchronised output
    input wire [W-1:0] i_async,
    output wire [W-1:0] o_sync
);

reg [W-1:0] meta_q;
reg [W-1:0] sync_q;

// first stage is read only by the second stage to contain metastability
always @(posedge i_core_clk) begin
    if (i_rst) begin
        meta_q <= {W{1'b0}};
        sync_q <= {W{1'b0}};
    end else begin
        meta_q <= i_async;
        sync_q <= meta_q;
    end
end

assign o_sync = sync_q;

endmodule // pab_sync

// *** hw/pab_gpio.v ***
// port a/b general purpose i/o with external bus takeover
`timescale 1ns/100ps
`include "pab_regs.vh"
module pab_gpio (
    // clock and reset
    input wire i_core_clk,
    input wire i_rst,
    // register port
    input wire [`PAB_ADDR_W-1:0] i_addr,
    input wire [`PAB_DATA_W-1:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    output wire [`PAB_DATA_W-1:0] o_rdata,
    // operating mode from the mode logic, same clock
    input wire [1:0] i_mode,
    // external bus side, same clock
    input wire [`PAB_EXT_ADDR_W-1:0] i_ext_addr,
    input wire [`PAB_DATA_W-1:0] i_internal_visibility_data,
    input wire i_ivd_phase,
    input wire [`PAB_DATA_W-1:0] i_ext_rdata,
    output wire o_ext_wr,
    output wire [`PAB_ADDR_W-1:0] o_ext_waddr,
    output wire [`PAB_DATA_W-1:0] o_ext_wdata,
    output wire o_upper_data_select,
    // port a pins
    input wire [`PAB_DATA_W-1:0] i_pa_pin,
    output wire [`PAB_DATA_W-1:0] o_pa_out,
    output wire [`PAB_DATA_W-1:0] o_pa_oe,
    // port b pins
    input wire [`PAB_DATA_W-1:0] i_port_b_data_bits,
    output wire [`PAB_DATA_W-1:0] o_port_b_data_bits,
    output wire [`PAB_DATA_W-1:0] o_port_b_oe
);

////////////////////////////////////////////////////////////////////////////////
// register decode

// one decoder shared by the write path and the read path
function [2:0] reg_sel;
    input [`PAB_ADDR_W-1:0] addr;
    begin
        case (addr)
            `PAB_OFF_A_DATA: reg_sel = `PAB_SEL_A_DATA;
            `PAB_OFF_B_DATA: reg_sel = `PAB_SEL_B_DATA;
            `PAB_OFF_A_DIR: reg_sel = `PAB_SEL_A_DIR;
            `PAB_OFF_B_DIR: reg_sel = `PAB_SEL_B_DIR;
            `PAB_OFF_STATUS: reg_sel = `PAB_SEL_STATUS;
            `PAB_OFF_A_PINS: reg_sel = `PAB_SEL_A_PINS;
            `PAB_OFF_B_PINS: reg_sel = `PAB_SEL_B_PINS;
            default: reg_sel = `PAB_SEL_NONE;
        endcase
    end
endfunction

wire [2:0] wr_sel;
wire [2:0] rd_sel;

assign wr_sel = reg_sel(i_addr);
assign rd_sel = reg_sel(i_addr);

////////////////////////////////////////////////////////////////////////////////
// mode decode

reg expanded;
reg emulation;
reg norm_exp;

// mode input comes from logic on this clock, so it is used unsynchronised
always @* begin
    expanded = 1'b0;
    emulation = 1'b0;
    norm_exp = 1'b0;
    case (i_mode)
        `PAB_MODE_SINGLE: begin
            expanded = 1'b0;
        end
        `PAB_MODE_NORM_EXP: begin
            expanded = 1'b1;
            norm_exp = 1'b1;
        end
        `PAB_MODE_EMU_SINGLE: begin
            emulation = 1'b1;
        end
        `PAB_MODE_EMU_EXP: begin
            expanded = 1'b1;
            emulation = 1'b1;
        end
        default: begin
            expanded = 1'b0;
        end
    endcase
end

// the external bus owns both ports whenever it runs
wire bus_owns_a;
wire bus_owns_b;

assign bus_owns_a = expanded | emulation;
assign bus_owns_b = expanded | emulation;

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers

wire [`PAB_DATA_W-1:0] pa_pin_s;
wire [`PAB_DATA_W-1:0] pb_pin_s;

// pins are asynchronous to the core clock
pab_sync #(
    .W(`PAB_DATA_W)
) u_sync_a (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_async(i_pa_pin),
    .o_sync(pa_pin_s)
);

pab_sync #(
    .W(`PAB_DATA_W)
) u_sync_b (
    .i_core_clk(i_core_clk),
    .i_rst(i_rst),
    .i_async(i_port_b_data_bits),
    .o_sync(pb_pin_s)
);

////////////////////////////////////////////////////////////////////////////////
// direction and data registers

reg [`PAB_DATA_W-1:0] port_a_direction_q;
reg [`PAB_DATA_W-1:0] port_b_direction_q;
reg [`PAB_DATA_W-1:0] port_a_data_q;
reg [`PAB_DATA_W-1:0] port_b_data_q;

// direction writes are taken in every mode; bus takeover never edits them
always @(posedge i_core_clk) begin
    if (i_rst) begin
        port_a_direction_q <= `PAB_RST_DIR;
        port_b_direction_q <= `PAB_RST_DIR;
    end else if (i_wr) begin
        if (wr_sel == `PAB_SEL_A_DIR) begin
            port_a_direction_q <= i_wdata;
        end
        if (wr_sel == `PAB_SEL_B_DIR) begin
            port_b_direction_q <= i_wdata;
        end
    end
end

// data registers keep their value while the bus owns the pins
always @(posedge i_core_clk) begin
    if (i_rst) begin
        port_a_data_q <= `PAB_RST_DATA;
        port_b_data_q <= `PAB_RST_DATA;
    end else if (i_wr) begin
        if (wr_sel == `PAB_SEL_A_DATA) begin
            port_a_data_q <= i_wdata;
        end
        if (wr_sel == `PAB_SEL_B_DATA) begin
            port_b_data_q <= i_wdata;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// forwarding of direction writes onto the external bus

reg ext_wr_q;
reg [`PAB_ADDR_W-1:0] ext_waddr_q;
reg [`PAB_DATA_W-1:0] ext_wdata_q;
wire dir_wr;

assign dir_wr = i_wr & ((wr_sel == `PAB_SEL_A_DIR) |
                        (wr_sel == `PAB_SEL_B_DIR));

// one-cycle write pulse in emulation, from the same edge that writes the register
always @(posedge i_core_clk) begin
    if (i_rst) begin
        ext_wr_q <= 1'b0;
        ext_waddr_q <= `PAB_OFF_A_DATA;
        ext_wdata_q <= `PAB_RST_ZERO;
    end else begin
        ext_wr_q <= dir_wr & emulation;
        if (dir_wr & emulation) begin
            ext_waddr_q <= i_addr;
            ext_wdata_q <= i_wdata;
        end
    end
end

assign o_ext_wr = ext_wr_q;
assign o_ext_waddr = ext_waddr_q;
assign o_ext_wdata = ext_wdata_q;

////////////////////////////////////////////////////////////////////////////////
// bus values presented on the pins

wire [`PAB_DATA_W-1:0] addr_lo;
wire [`PAB_DATA_W-1:0] addr_hi;
wire [`PAB_DATA_W-1:0] pb_bus_val;

assign addr_lo = i_ext_addr[`PAB_ADDR_LO_MSB:`PAB_ADDR_LO_LSB];
assign addr_hi = i_ext_addr[`PAB_ADDR_HI_MSB:`PAB_ADDR_HI_LSB];

// emulation alternates address and visibility data under the bus phase
assign pb_bus_val = (emulation & i_ivd_phase) ?
                    i_internal_visibility_data :
                    addr_lo;

////////////////////////////////////////////////////////////////////////////////
// per-pin output muxes

reg [`PAB_DATA_W-1:0] pa_out_q;
reg [`PAB_DATA_W-1:0] pa_oe_q;
reg [`PAB_DATA_W-1:0] pb_out_q;
reg [`PAB_DATA_W-1:0] pb_oe_q;
wire [`PAB_DATA_W-1:0] pa_out_d;
wire [`PAB_DATA_W-1:0] pa_oe_d;
wire [`PAB_DATA_W-1:0] pb_out_d;
wire [`PAB_DATA_W-1:0] pb_oe_d;

genvar gi;
generate
    for (gi = 0; gi < `PAB_DATA_W; gi = gi + 1) begin : g_pin
        // port a: bus address high byte or plain gpio
        assign pa_out_d[gi] = bus_owns_a ? addr_hi[gi] :
                              port_a_data_q[gi];
        assign pa_oe_d[gi] = bus_owns_a | port_a_direction_q[gi];
        if (gi == `PAB_UDS_BIT) begin : g_uds
            // pin 0 turns into an input in normal expanded mode
            assign pb_out_d[gi] = (bus_owns_b & ~norm_exp) ?
                                  pb_bus_val[gi] :
                                  port_b_data_q[gi];
            assign pb_oe_d[gi] = norm_exp ? 1'b0 :
                                 (bus_owns_b |
                                  port_b_direction_q[gi]);
        end else begin : g_plain
            assign pb_out_d[gi] = bus_owns_b ? pb_bus_val[gi] :
                                  port_b_data_q[gi];
            assign pb_oe_d[gi] = bus_owns_b |
                                 port_b_direction_q[gi];
        end
    end
endgenerate

// registered pin drive keeps glitches from mode changes off the pads
always @(posedge i_core_clk) begin
    if (i_rst) begin
        pa_out_q <= `PAB_RST_ZERO;
        pa_oe_q <= `PAB_RST_ZERO;
        pb_out_q <= `PAB_RST_ZERO;
        pb_oe_q <= `PAB_RST_ZERO;
    end else begin
        pa_out_q <= pa_out_d;
        pa_oe_q <= pa_oe_d;
        pb_out_q <= pb_out_d;
        pb_oe_q <= pb_oe_d;
    end
end

assign o_pa_out = pa_out_q;
assign o_pa_oe = pa_oe_q;
assign o_port_b_data_bits = pb_out_q;
assign o_port_b_oe = pb_oe_q;

////////////////////////////////////////////////////////////////////////////////
// upper data select input

reg uds_q;

// only meaningful in normal expanded mode; held low otherwise
always @(posedge i_core_clk) begin
    if (i_rst) begin
        uds_q <= 1'b0;
    end else begin
        uds_q <= norm_exp & pb_pin_s[`PAB_UDS_BIT];
    end
end

assign o_upper_data_select = uds_q;

////////////////////////////////////////////////////////////////////////////////
// read path

reg [`PAB_DATA_W-1:0] rdata_d;
reg [`PAB_DATA_W-1:0] rdata_q;
reg [`PAB_DATA_W-1:0] status;

// status shows the block's own view of mode and ownership
always @* begin
    status = `PAB_RST_ZERO;
    status[`PAB_ST_EXPANDED] = expanded;
    status[`PAB_ST_EMULATION] = emulation;
    status[`PAB_ST_A_OWNED] = bus_owns_a;
    status[`PAB_ST_B_OWNED] = bus_owns_b;
    status[`PAB_ST_UDS_IN] = uds_q;
    status[`PAB_ST_IVD_PHASE] = i_ivd_phase;
end

// data reads mix register and pin per direction bit
always @* begin
    rdata_d = `PAB_RST_ZERO;
    case (rd_sel)
        `PAB_SEL_A_DATA: begin
            rdata_d = (port_a_direction_q & port_a_data_q) |
                      (~port_a_direction_q & pa_pin_s);
        end
        `PAB_SEL_B_DATA: begin
            rdata_d = (port_b_direction_q & port_b_data_q) |
                      (~port_b_direction_q & pb_pin_s);
        end
        `PAB_SEL_A_DIR: begin
            rdata_d = emulation ? i_ext_rdata :
                      port_a_direction_q;
        end
        `PAB_SEL_B_DIR: begin
            rdata_d = emulation ? i_ext_rdata :
                      port_b_direction_q;
        end
        `PAB_SEL_STATUS: begin
            rdata_d = status;
        end
        `PAB_SEL_A_PINS: begin
            rdata_d = pa_pin_s;
        end
        `PAB_SEL_B_PINS: begin
            rdata_d = pb_pin_s;
        end
        default: begin
            rdata_d = `PAB_RST_ZERO;
        end
    endcase
end

// read data stand only in the cycle after the strobe, zero otherwise
always @(posedge i_core_clk) begin
    if (i_rst) begin
        rdata_q <= `PAB_RST_ZERO;
    end else if (i_rd) begin
        rdata_q <= rdata_d;
    end else begin
        rdata_q <= `PAB_RST_ZERO;
    end
end

assign o_rdata = rdata_q;

endmodule // pab_gpio

// *** tb/pab_gpio_monitor.sv ***
// concurrent checks on the ports of the port a/b gpio block
`timescale 1ns/100ps
`include "pab_regs.vh"
module pab_gpio_monitor (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // register port
    input wire logic [`PAB_ADDR_W-1:0] i_addr,
    input wire logic [`PAB_DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [`PAB_DATA_W-1:0] o_rdata,
    // mode and external bus
    input wire logic [1:0] i_mode,
    input wire logic [`PAB_EXT_ADDR_W-1:0] i_ext_addr,
    input wire logic [`PAB_DATA_W-1:0] i_internal_visibility_data,
    input wire logic i_ivd_phase,
    input wire logic [`PAB_DATA_W-1:0] i_ext_rdata,
    input wire logic o_ext_wr,
    input wire logic [`PAB_ADDR_W-1:0] o_ext_waddr,
    input wire logic [`PAB_DATA_W-1:0] o_ext_wdata,
    input wire logic o_upper_data_select,
    // pins
    input wire logic [`PAB_DATA_W-1:0] i_port_b_data_bits,
    input wire logic [`PAB_DATA_W-1:0] o_pa_out,
    input wire logic [`PAB_DATA_W-1:0] o_pa_oe,
    input wire logic [`PAB_DATA_W-1:0] o_port_b_data_bits,
    input wire logic [`PAB_DATA_W-1:0] o_port_b_oe
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    // direction register decode, shared by the emulation checks
    wire logic dir_acc;
    assign dir_acc = (i_addr == `PAB_OFF_A_DIR) || (i_addr == `PAB_OFF_B_DIR);
    ////////////////////////////////////////////////////////////////////////
    AST_RD_IDLE: assert property (!i_rd |=> o_rdata == 8'h00)
        else $error("read data not zero outside a read answer");
    AST_EXP_OE: assert property ((i_mode == `PAB_MODE_NORM_EXP) |=>
        (o_pa_oe == 8'hFF && o_port_b_oe == 8'hFE))
        else $error("expanded mode output enables wrong");
    AST_EXP_ADDR: assert property ((i_mode == `PAB_MODE_NORM_EXP) |=>
        (o_pa_out == $past(i_ext_addr[15:8]) &&
        o_port_b_data_bits[7:1] == $past(i_ext_addr[7:1])))
        else $error("expanded mode address on pins wrong");
    AST_EMU_MUX: assert property (i_mode[1] |=>
        (o_port_b_oe == 8'hFF &&
        o_port_b_data_bits == ($past(i_ivd_phase) ?
        $past(i_internal_visibility_data) : $past(i_ext_addr[7:0]))))
        else $error("emulation port b multiplex wrong");
    AST_EXT_WR: assert property (i_wr && i_mode[1] && dir_acc |=>
        (o_ext_wr && o_ext_waddr == $past(i_addr) &&
        o_ext_wdata == $past(i_wdata)))
        else $error("direction write not forwarded");
    AST_NO_FWD: assert property (!(i_wr && i_mode[1] && dir_acc) |=>
        !o_ext_wr)
        else $error("spurious external write");
    AST_EMU_RD: assert property (i_rd && i_mode[1] && dir_acc |=>
        o_rdata == $past(i_ext_rdata))
        else $error("emulation direction read not from bus");
    AST_UDS_IN: assert property ((i_mode == `PAB_MODE_NORM_EXP)[*4] |->
        o_upper_data_select == $past(i_port_b_data_bits[0], 3))
        else $error("upper data select does not follow pin");
    AST_UDS_OFF: assert property ((i_mode != `PAB_MODE_NORM_EXP) |=>
        !o_upper_data_select)
        else $error("upper data select active outside expanded");
    // main scenarios
    cover property (i_wr && i_mode[1] && dir_acc);
    cover property (i_rd && i_mode[1] && dir_acc);
    cover property (i_rd && i_mode == `PAB_MODE_NORM_EXP);
endmodule // pab_gpio_monitor

bind pab_gpio pab_gpio_monitor pab_gpio_monitor_inst (.i_core_clk, .i_rst,
    .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_mode, .i_ext_addr,
    .i_internal_visibility_data, .i_ivd_phase, .i_ext_rdata, .o_ext_wr,
    .o_ext_waddr, .o_ext_wdata, .o_upper_data_select, .i_port_b_data_bits,
    .o_pa_out, .o_pa_oe, .o_port_b_data_bits, .o_port_b_oe);

// *** tb/pab_pins_model.sv ***
// pin wiring and external bus device facing the port a/b gpio block
`timescale 1ns/100ps
module pab_pins_model (
    // clock and reset
    input wire logic i_core_clk,
    input wire logic i_rst,
    // drive from the block and from outside circuitry
    input wire logic [7:0] i_pa_out,
    input wire logic [7:0] i_pa_oe,
    input wire logic [7:0] i_pb_out,
    input wire logic [7:0] i_pb_oe,
    input wire logic [7:0] i_pa_ext,
    input wire logic [7:0] i_pb_ext,
    // forwarded writes from the block
    input wire logic i_ext_wr,
    input wire logic [7:0] i_ext_wdata,
    // resolved pin levels and bus read data
    output wire logic [7:0] o_pa_pin,
    output wire logic [7:0] o_pb_pin,
    output wire logic [7:0] o_ext_rdata
);
    logic [7:0] ext_q;
    // outside circuitry drives only pins that the block leaves as input
    assign o_pa_pin = (i_pa_oe & i_pa_out) | (~i_pa_oe & i_pa_ext);
    assign o_pb_pin = (i_pb_oe & i_pb_out) | (~i_pb_oe & i_pb_ext);
    // bus device keeps the last forwarded byte and answers with it
    always @(posedge i_core_clk) begin
        if (i_rst) begin
            ext_q <= 8'h00;
        end else if (i_ext_wr) begin
            ext_q <= i_ext_wdata;
        end
    end
    assign o_ext_rdata = ext_q;
endmodule // pab_pins_model

// *** tb/test_pab_gpio.sv ***
// self-checking bench for the port a/b gpio block
`timescale 1ns/100ps
`include "pab_regs.vh"
module test_pab_gpio;
    typedef struct {logic p; logic [7:0] dir, dat, ext, rd;} pab_row_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd_s = 1'b0;
    logic [1:0] mode = `PAB_MODE_SINGLE;
    logic ivd_ph = 1'b0;
    logic [7:0] pa_ext = 8'h00;
    logic [7:0] pb_ext = 8'h00;
    logic [15:0] ext_a = 16'hBEEF;
    wire [7:0] rdata, ext_rd, ext_wd, pa_pin, pb_pin, pa_out, pa_oe;
    wire [7:0] pb_out, pb_oe;
    wire [3:0] ext_wa;
    wire ext_wr, upper_data_select;
    int n_fail = 0;
    int checked = 0;
    // port, direction, data, outside level, expected data read
    pab_row_t rows [0:3] = '{'{1'b0, 8'hF0, 8'h5A, 8'h33, 8'h53},
        '{1'b0, 8'h00, 8'hFF, 8'hC3, 8'hC3},
        '{1'b1, 8'hFF, 8'h12, 8'h00, 8'h12},
        '{1'b1, 8'h0F, 8'hA6, 8'h99, 8'h96}};
    ////////////////////////////////////////////////////////////////////////
    always #2.5 clk = ~clk;
    pab_gpio pab_gpio_inst (.i_core_clk(clk), .i_rst(rst), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd_s), .o_rdata(rdata),
        .i_mode(mode), .i_ext_addr(ext_a),
        .i_internal_visibility_data(8'h5C), .i_ivd_phase(ivd_ph),
        .i_ext_rdata(ext_rd), .o_ext_wr(ext_wr), .o_ext_waddr(ext_wa),
        .o_ext_wdata(ext_wd), .o_upper_data_select(upper_data_select), .i_pa_pin(pa_pin),
        .o_pa_out(pa_out), .o_pa_oe(pa_oe), .i_port_b_data_bits(pb_pin),
        .o_port_b_data_bits(pb_out), .o_port_b_oe(pb_oe));
    pab_pins_model pab_pins_model_inst (.i_core_clk(clk), .i_rst(rst),
        .i_pa_out(pa_out), .i_pa_oe(pa_oe), .i_pb_out(pb_out),
        .i_pb_oe(pb_oe), .i_pa_ext(pa_ext), .i_pb_ext(pb_ext),
        .i_ext_wr(ext_wr), .i_ext_wdata(ext_wd), .o_pa_pin(pa_pin),
        .o_pb_pin(pb_pin), .o_ext_rdata(ext_rd));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [7:0] e,
        input logic [7:0] g);
        checked++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // one-cycle write strobe; ends just after the edge that takes it
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    // read data stand only in the cycle after the strobe edge
    task automatic rd_reg(input logic [3:0] a, input logic [7:0] e,
        input string nm);
        @(posedge clk);
        rd_s <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        chk(nm, e, rdata);
    endtask
    task final_report;
        if (n_fail == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    // watchdog: the sequence needs well under a thousand cycles
    initial begin
        #20000;
        n_fail++;
        final_report();
    end
    initial begin
        cyc(4);
        rst <= 1'b0;
        cyc(1);
        chk("oe a rst", 8'h00, pa_oe);
        chk("oe b rst", 8'h00, pb_oe);
        rd_reg(`PAB_OFF_A_DIR, 8'h00, "dir a rst");
        rd_reg(`PAB_OFF_B_DIR, 8'h00, "dir b rst");
        foreach (rows[k]) begin
            wr_reg(rows[k].p ? `PAB_OFF_B_DIR : `PAB_OFF_A_DIR,
                rows[k].dir);
            wr_reg(rows[k].p ? `PAB_OFF_B_DATA : `PAB_OFF_A_DATA,
                rows[k].dat);
            if (rows[k].p) pb_ext <= rows[k].ext;
            else pa_ext <= rows[k].ext;
            cyc(3);
            chk("oe", rows[k].dir, rows[k].p ? pb_oe : pa_oe);
            chk("out", rows[k].dat, rows[k].p ? pb_out : pa_out);
            rd_reg(rows[k].p ? `PAB_OFF_B_DATA : `PAB_OFF_A_DATA,
                rows[k].rd, "data");
        end
        // unmapped offset keeps nothing
        wr_reg(4'hF, 8'hFF);
        rd_reg(4'hF, 8'h00, "unmapped");
        // normal expanded: bus takes both ports, pin 0 of b turns input
        wr_reg(`PAB_OFF_A_DIR, 8'h3C);
        mode <= `PAB_MODE_NORM_EXP;
        pb_ext <= 8'h01;
        cyc(5);
        chk("exp oe b", 8'hFE, pb_oe);
        chk("exp addr a", 8'hBE, pa_out);
        chk("exp addr b", 8'hEE, pb_out & 8'hFE);
        chk("uds", 8'h01, {7'h00, upper_data_select});
        wr_reg(`PAB_OFF_B_DIR, 8'h77);
        rd_reg(`PAB_OFF_B_DIR, 8'h77, "exp dir b");
        // emulation single, then expanded with the visibility multiplex
        mode <= `PAB_MODE_EMU_SINGLE;
        cyc(2);
        chk("emu1 oe b", 8'hFF, pb_oe);
        mode <= `PAB_MODE_EMU_EXP;
        ivd_ph <= 1'b1;
        cyc(2);
        chk("ivd", 8'h5C, pb_out);
        chk("emu oe a", 8'hFF, pa_oe);
        ivd_ph <= 1'b0;
        // a new bus address proves the pins follow it, not a fixed value
        ext_a <= 16'h1234;
        cyc(2);
        chk("addr lo", 8'h34, pb_out);
        rd_reg(`PAB_OFF_STATUS, 8'h0F, "status");
        wr_reg(`PAB_OFF_B_DIR, 8'hA5);
        chk("fwd strobe", 8'h01, {7'h00, ext_wr});
        chk("fwd data", 8'hA5, ext_wd);
        chk("fwd addr", {4'h0, `PAB_OFF_B_DIR}, {4'h0, ext_wa});
        // local a holds 3c, so a bus answer of a5 tells the two apart
        rd_reg(`PAB_OFF_A_DIR, 8'hA5, "emu dir a");
        mode <= `PAB_MODE_SINGLE;
        rd_reg(`PAB_OFF_B_DIR, 8'hA5, "local dir b");
        cyc(2);
        chk("oe a kept", 8'h3C, pa_oe);
        chk("oe b kept", 8'hA5, pb_oe);
        // driven bits show data a6, the input bits show the outside level
        rd_reg(`PAB_OFF_B_PINS, 8'hA4, "pins b");
        // second reset in mid-run
        rst <= 1'b1;
        cyc(2);
        chk("oe b rst2", 8'h00, pb_oe);
        rst <= 1'b0;
        rd_reg(`PAB_OFF_B_DIR, 8'h00, "dir b rst2");
        final_report();
    end
endmodule // test_pab_gpio
